// File: bench/host_model.sv
`timescale 1ns/1ps
module host_model #(
  parameter int GAP_NS = 1000
) (
  output logic      spi_clk,
  output logic      target_select_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic attention_request_n
);
  typedef logic [7:0] bq_t[$];

  initial begin
    spi_clk = 1'b0;
    target_select_n = 1'b0;
    mosi = 1'b1;
    // a real rising select edge clears the link side's async state
    #1 target_select_n = 1'b1;
  end

  // edges sit 0.3 ns off the system clock grid; spacing scaled down
  task automatic sel(input logic v);
    if (v) begin
      #31.7;
      target_select_n = 1'b1;
      mosi = ~mosi;
      #(GAP_NS);
    end else begin
      #32.3;
      target_select_n = 1'b0;
    end
  endtask

  // mode 0, msb first, clock stands low between bytes of no frame
  task automatic xbyte(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi = t[i];
      #32;
      spi_clk = 1'b1;
      r[i] = miso;
      #32;
      spi_clk = 1'b0;
    end
  endtask

  task automatic transact(input bq_t c, output bq_t r, output bit ok);
    logic [7:0] b;
    int         n;
    r = {};
    sel(1'b0);
    foreach (c[i]) xbyte(c[i], b);
    for (n = 0; n < 40 && attention_request_n !== 1'b0; n++) #64;
    ok = (n < 40);
    b = 8'hFF;
    for (n = 0; n < 8 && b === 8'hFF; n++) xbyte(8'hFF, b);
    r.push_back(b);
    n = (b > 8'h04) ? 1 : 2;
    if (b === 8'hFE) begin
      xbyte(8'hFF, b);
      r.push_back(b);
      n = int'(b) + 1;
    end
    repeat (n) begin
      xbyte(8'hFF, b);
      r.push_back(b);
    end
    ok = ok && r[0] !== 8'hFF && r[$] === 8'hA7;
    sel(1'b1);
  endtask
endmodule

// File: bench/spi_proto_checker.sv
`timescale 1ns/1ps
module spi_proto_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic spi_clk,
  input wire logic target_select_n,
  input wire logic wake_request_n,
  input wire logic network_state_event,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic attention_request_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_sel_rise;
    $rose(target_select_n);
  endsequence
  sequence s_sel_fall;
    $fell(target_select_n);
  endsequence

  property p_miso_idle;
    target_select_n |-> miso;
  endproperty
  property p_oe_off;
    s_sel_rise |-> ##[1:3] miso_oe_n;
  endproperty
  property p_oe_on;
    s_sel_fall |-> ##[1:3] !miso_oe_n;
  endproperty
  property p_first_ff;
    s_sel_fall |-> miso[*6];
  endproperty
  property p_miso_steady;
    !target_select_n && !$past(target_select_n) && spi_clk && $past(spi_clk)
      |-> $stable(miso);
  endproperty
  property p_rst_notify;
    $fell(srst) && target_select_n |-> ##[1:4] !attention_request_n;
  endproperty
  property p_wake_on;
    $fell(wake_request_n) && target_select_n |-> ##[1:4] !attention_request_n;
  endproperty
  property p_wake_off;
    $rose(wake_request_n) && target_select_n |-> ##[1:4] attention_request_n;
  endproperty
  property p_event;
    network_state_event && target_select_n && $past(target_select_n, 4)
      |-> ##[1:4] !attention_request_n;
  endproperty

  a_miso_idle: assert property (p_miso_idle)
    else $error("miso not high while deselected");
  a_oe_off: assert property (p_oe_off)
    else $error("miso driver not released");
  a_oe_on: assert property (p_oe_on)
    else $error("miso driver not enabled");
  a_first_ff: assert property (p_first_ff)
    else $error("first byte of frame not idle fill");
  a_miso_steady: assert property (p_miso_steady)
    else $error("miso changed while link clock high");
  a_rst_notify: assert property (p_rst_notify)
    else $error("no attention after reset");
  a_wake_on: assert property (p_wake_on)
    else $error("wake request not answered");
  a_wake_off: assert property (p_wake_off)
    else $error("attention held after wake release");
  a_event: assert property (p_event)
    else $error("pending callback not signalled");
endmodule

bind spi_host_command_protocol spi_proto_checker u_checker (
  .clk_sys            (clk_sys),
  .srst               (srst),
  .spi_clk            (spi_clk),
  .target_select_n    (target_select_n),
  .wake_request_n     (wake_request_n),
  .network_state_event(network_state_event),
  .miso               (miso),
  .miso_oe_n          (miso_oe_n),
  .attention_request_n(attention_request_n)
);

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  typedef logic [7:0] bq_t[$];
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        wake_request_n = 1'b1;
  logic        network_state_event = 1'b0;
  logic [7:0]  network_state_status = 8'h00;
  logic [31:0] rng = 32'h9DBA;
  logic [7:0]  cb_stat;
  logic [7:0]  b;
  bit          rst_pend = 1'b1;
  bit          cb_pend = 1'b0;
  int          n_mismatch = 0;
  int          num_checks = 0;
  bq_t         c;
  wire logic   spi_clk, target_select_n, mosi, miso, attention_request_n;
  wire logic   miso_oe_n;

  always #2.5 clk_sys = ~clk_sys;

  spi_host_command_protocol DUT (
    .clk_sys(clk_sys),
    .srst(srst),
    .spi_clk(spi_clk),
    .target_select_n(target_select_n),
    .mosi(mosi),
    .wake_request_n(wake_request_n),
    .network_state_event(network_state_event),
    .network_state_status(network_state_status),
    .miso(miso),
    .miso_oe_n(miso_oe_n),
    .attention_request_n(attention_request_n)
  );

  host_model host (
    .spi_clk(spi_clk),
    .target_select_n(target_select_n),
    .mosi(mosi),
    .miso(miso),
    .attention_request_n(attention_request_n)
  );

  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction

  function automatic bq_t frame(input logic [7:0] id, input int np);
    bq_t f;
    f = '{8'hFE, 8'(np + 3), rnd(), 8'h00, id};
    repeat (np) f.push_back(rnd());
    f.push_back(8'hA7);
    return f;
  endfunction

  function automatic bq_t expect_of(input bq_t c);
    bq_t e;
    int  l;
    l = (c.size() > 1) ? int'(c[1]) : 0;
    if (rst_pend) e = '{8'h00, 8'h02};
    else if (c[0] == 8'h0A) e = '{8'h82};
    else if (c[0] == 8'h0B) e = '{8'hC1};
    else if (c[0] != 8'hFE) e = '{8'h04, 8'h00};
    else if (l > 133) e = '{8'h01, 8'h00};
    else if (c.size() < l + 3 || c[l + 2] != 8'hA7) e = '{8'h03, 8'h00};
    else if (c[4] == 8'h00)
      e = '{8'hFE, 8'h07, c[2], 8'h80, 8'h00, 8'h04, 8'h02, 8'h10, 8'h47};
    else if (c[4] == 8'h06 && cb_pend)
      e = '{8'hFE, 8'h04, c[2], 8'h80, 8'h19, cb_stat};
    else e = '{8'hFE, 8'h03, c[2], 8'h80, c[4]};
    e.push_back(8'hA7);
    return e;
  endfunction

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wait_attn(input logic v, input string what);
    int n;
    for (n = 0; n < 60 && attention_request_n !== v; n++)
      @(negedge clk_sys);
    check(what, 16'(attention_request_n), 16'(v));
    if (n == 60) report_and_stop();
  endtask

  task automatic run(input bq_t c, input string name);
    bq_t r;
    bq_t e;
    bit  ok;
    e = expect_of(c);
    host.transact(c, r, ok);
    check("reply found", 16'(ok), 16'h0001);
    if (!ok) report_and_stop();
    check("reply length", 16'(r.size()), 16'(e.size()));
    foreach (e[i]) check("reply byte", 16'(r[i]), 16'(e[i]));
    check("driver released", 16'(miso_oe_n), 16'h0001);
    if (rst_pend) rst_pend = 1'b0;
    else if (c[0] == 8'hFE && c[4] == 8'h06) cb_pend = 1'b0;
    $display("test %s done", name);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    wait_attn(1'b0, "reset notify");
    repeat (4) @(posedge clk_sys);
    run(frame(8'h06, 0), "reset report");
    check("no more data", 16'(attention_request_n), 16'h0001);
    @(posedge clk_sys) wake_request_n <= 1'b0;
    wait_attn(1'b0, "wake answer");
    @(posedge clk_sys) wake_request_n <= 1'b1;
    repeat (6) @(negedge clk_sys);
    check("wake release", 16'(attention_request_n), 16'h0001);
    $display("test wake done");
    run('{8'h0A, 8'hA7}, "version");
    run('{8'h0B, 8'hA7}, "status");
    run('{8'h33, 8'hA7}, "unsupported");
    run(frame(8'h00, 1), "frame version");
    repeat (4) run(frame((rnd() & 8'h1F) | 8'h20, int'(rnd() & 8'h03)),
                   "unknown id");
    for (int k = 0; k < 2; k++) begin
      cb_stat = k ? rnd() : 8'h91;
      fork
        if (k) run('{8'h0A, 8'hA7}, "busy version");
        begin
          repeat (k ? 40 : 1) @(posedge clk_sys);
          network_state_status <= cb_stat;
          network_state_event <= 1'b1;
          @(posedge clk_sys) network_state_event <= 1'b0;
        end
      join
      cb_pend = 1'b1;
      wait_attn(1'b0, "callback notify");
      run(frame(8'h06, 0), "callback");
      check("no more data", 16'(attention_request_n), 16'h0001);
    end
    run('{8'hFE, 8'h86}, "oversize");
    run(frame(8'h2A, 130), "longest frame");
    c = frame(8'h21, 0);
    c[5] = 8'h5A;
    run(c, "no terminator");
    host.sel(1'b0);
    host.xbyte(8'hFE, b);
    host.xbyte(8'h04, b);
    host.sel(1'b1);
    run('{8'h0A, 8'hA7}, "abort");
    host.sel(1'b0);
    @(posedge clk_sys) srst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (8) @(negedge clk_sys);
    for (int k = 0; k < 5; k++) begin
      host.xbyte(k == 0 ? 8'h0A : (k == 1 ? 8'hA7 : 8'hFF), b);
      check("ignored traffic", 16'(b), 16'h00FF);
    end
    host.sel(1'b1);
    rst_pend = 1'b1;
    wait_attn(1'b0, "reset notify");
    run('{8'h0A, 8'hA7}, "second reset");
    report_and_stop();
  end
endmodule

// File: rtl/frame_store.sv
`timescale 1ns/1ps
module frame_store #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 256
) (
  input  wire logic                     clk_sys,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_data <= mem_q[rd_addr];
  end

endmodule

// File: rtl/spi_host_command_protocol.sv
`timescale 1ns/1ps
module spi_host_command_protocol
  import spi_proto_pkg::*;
#(
  parameter logic [7:0]  API_VERSION_VALUE = 8'h04,
  parameter logic [7:0]  FIRMWARE_KIND     = 8'h02,
  parameter logic [7:0]  FIRMWARE_REV_HI   = 8'h10,
  parameter logic [7:0]  FIRMWARE_REV_LO   = 8'h47,
  parameter int unsigned FRAME_DEPTH       = 256
) (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       spi_clk,
  input  wire logic       target_select_n,
  input  wire logic       mosi,
  input  wire logic       wake_request_n,
  input  wire logic       network_state_event,
  input  wire logic [7:0] network_state_status,
  output logic            miso,
  output logic            miso_oe_n,
  output logic            attention_request_n
);

  localparam int unsigned AW = $clog2(FRAME_DEPTH);

  generate
    if (FRAME_DEPTH < int'(MAX_FRAME_LEN) + 1 || FRAME_DEPTH > 256) begin
      $error("FRAME_DEPTH must hold a full frame and fit 8-bit indices");
    end
  endgenerate

  // link side
  logic [7:0] rx_byte;
  logic       rx_toggle;
  logic [7:0] tx_byte_q;

  spi_link_shifter u_shifter (
    .spi_clk         (spi_clk),
    .target_select_n (target_select_n),
    .mosi            (mosi),
    .tx_byte         (tx_byte_q),
    .miso            (miso),
    .rx_byte         (rx_byte),
    .rx_toggle       (rx_toggle)
  );

  // synchronisers into clk_sys
  logic sel_n_s1_q, sel_n_s2_q, sel_n_s3_q;
  logic tog_s1_q, tog_s2_q, tog_s3_q;
  logic wake_n_s1_q, wake_n_s2_q, wake_n_s3_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // select counts as busy until seen idle after reset
      {sel_n_s3_q, sel_n_s2_q, sel_n_s1_q}    <= 3'h0;
      {tog_s3_q, tog_s2_q, tog_s1_q}          <= 3'h0;
      {wake_n_s3_q, wake_n_s2_q, wake_n_s1_q} <= 3'h7;
    end else begin
      {sel_n_s3_q, sel_n_s2_q, sel_n_s1_q} <=
        {sel_n_s2_q, sel_n_s1_q, target_select_n};
      {tog_s3_q, tog_s2_q, tog_s1_q} <=
        {tog_s2_q, tog_s1_q, rx_toggle};
      {wake_n_s3_q, wake_n_s2_q, wake_n_s1_q} <=
        {wake_n_s2_q, wake_n_s1_q, wake_request_n};
    end
  end

  logic rx_evt, sel_idle, sel_rise, sel_fall, wake_on, wake_off;
  assign rx_evt   = tog_s2_q ^ tog_s3_q;
  assign sel_idle = sel_n_s2_q;
  assign sel_rise = sel_n_s2_q & ~sel_n_s3_q;
  assign sel_fall = ~sel_n_s2_q & sel_n_s3_q;
  assign wake_on  = ~wake_n_s2_q;
  assign wake_off = wake_n_s2_q & ~wake_n_s3_q;
  assign miso_oe_n = sel_n_s2_q;

  // protocol state
  state_t     state_q;
  resp_t      kind_q;
  logic [7:0] cmd_q, len_q, cnt_q, seq_q, id_q, head_q, aux_q;
  logic [3:0] idx_q, last_q;
  logic [1:0] dec_q;
  logic       resp_ready_q;
  logic       reset_pending_q, cb_pending_q, notify_q;
  logic [7:0] cb_status_q;
  logic [7:0] rd_data;
  logic       take_reset, take_cb;

  frame_store #(
    .WIDTH (8),
    .DEPTH (FRAME_DEPTH)
  ) u_store (
    .clk_sys (clk_sys),
    .wr_en   (state_q == ST_BODY && rx_evt && !sel_idle),
    .wr_addr (cnt_q[AW-1:0]),
    .wr_data (rx_byte),
    .rd_addr (dec_q == 2'h0 ? OFS_SEQ[AW-1:0] : OFS_ID[AW-1:0]),
    .rd_data (rd_data)
  );

  // decode outcome taken at the last decode step
  logic dec_final;
  assign dec_final  = state_q == ST_DECODE && dec_q == DEC_DONE && !sel_idle;
  assign take_reset = dec_final && reset_pending_q;
  assign take_cb    = dec_final && !reset_pending_q && cmd_q == CMD_FRAME
                      && id_q == ID_CALLBACK && cb_pending_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q      <= ST_IGNORE;
      kind_q       <= R_SHORT;
      cmd_q        <= 8'h00;
      len_q        <= 8'h00;
      cnt_q        <= 8'h00;
      seq_q        <= 8'h00;
      id_q         <= 8'h00;
      head_q       <= 8'h00;
      aux_q        <= 8'h00;
      idx_q        <= 4'h0;
      last_q       <= 4'h0;
      dec_q        <= 2'h0;
      resp_ready_q <= 1'b0;
    end else if (sel_idle) begin
      state_q      <= ST_IDLE;
      resp_ready_q <= 1'b0;
      dec_q        <= 2'h0;
    end else begin
      case (state_q)
        ST_IGNORE, ST_DONE: begin
          state_q <= state_q;
        end
        ST_IDLE: if (rx_evt) begin
          cmd_q <= rx_byte;
          cnt_q <= 8'h00;
          if (rx_byte == CMD_FRAME) begin
            state_q <= ST_LEN;
          end else if (rx_byte == CMD_VERSION ||
                       rx_byte == CMD_STATUS) begin
            state_q <= ST_TERM;
          end else begin
            kind_q       <= R_ERR;
            head_q       <= ERR_UNSUPPORTED;
            aux_q        <= ERR_RESERVED;
            last_q       <= LAST_ERR;
            resp_ready_q <= 1'b1;
            state_q      <= ST_DRAIN;
          end
        end
        ST_LEN: if (rx_evt) begin
          len_q <= rx_byte;
          if (rx_byte > MAX_FRAME_LEN) begin
            kind_q       <= R_ERR;
            head_q       <= ERR_OVERSIZE;
            aux_q        <= ERR_RESERVED;
            last_q       <= LAST_ERR;
            resp_ready_q <= 1'b1;
            state_q      <= ST_DRAIN;
          end else if (rx_byte == 8'h00) begin
            state_q <= ST_TERM;
          end else begin
            state_q <= ST_BODY;
          end
        end
        ST_BODY: if (rx_evt) begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == len_q - 8'h01) begin
            state_q <= ST_TERM;
          end
        end
        ST_TERM: if (rx_evt) begin
          if (rx_byte == FRAME_END) begin
            state_q <= ST_DECODE;
            dec_q   <= 2'h0;
          end else begin
            kind_q       <= R_ERR;
            head_q       <= ERR_NO_END;
            aux_q        <= ERR_RESERVED;
            last_q       <= LAST_ERR;
            resp_ready_q <= 1'b1;
            state_q      <= ST_DRAIN;
          end
        end
        ST_DECODE: begin
          dec_q <= dec_q + 2'h1;
          if (dec_q == 2'h1) begin
            seq_q <= rd_data;
          end
          if (dec_q == 2'h2) begin
            id_q <= rd_data;
          end
          if (dec_q == DEC_DONE) begin
            idx_q        <= 4'h0;
            resp_ready_q <= 1'b1;
            state_q      <= ST_SEND;
            if (reset_pending_q) begin
              kind_q <= R_ERR;
              head_q <= ERR_RESET;
              aux_q  <= POWER_ON_RESET_CAUSE;
              last_q <= LAST_ERR;
            end else if (cmd_q == CMD_VERSION) begin
              kind_q <= R_SHORT;
              head_q <= VERSION_REPLY;
              last_q <= LAST_SHORT;
            end else if (cmd_q == CMD_STATUS) begin
              kind_q <= R_SHORT;
              head_q <= STATUS_ALIVE;
              last_q <= LAST_SHORT;
            end else if (id_q == ID_VERSION) begin
              kind_q <= R_FRAME;
              len_q  <= LEN_VERSION_RESP;
              last_q <= LAST_VERSION;
            end else if (take_cb) begin
              kind_q <= R_FRAME;
              id_q   <= ID_NETWORK_STATE;
              len_q  <= LEN_CB_RESP;
              last_q <= LAST_CB;
            end else begin
              kind_q <= R_FRAME;
              len_q  <= LEN_EMPTY_RESP;
              last_q <= LAST_EMPTY;
            end
          end
        end
        ST_DRAIN: if (rx_evt && rx_byte == IDLE_FILL) begin
          idx_q        <= 4'h0;
          resp_ready_q <= 1'b0;
          state_q      <= ST_SEND;
        end
        ST_SEND: if (rx_evt) begin
          resp_ready_q <= 1'b0;
          if (idx_q == last_q) begin
            state_q <= ST_DONE;
          end else begin
            idx_q <= idx_q + 4'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // reply byte at the current index; terminator closes every reply
  logic [7:0] resp_byte;
  logic [7:0] param [4];

  always_comb begin
    if (id_q == ID_VERSION) begin
      param[0] = API_VERSION_VALUE;
      param[1] = FIRMWARE_KIND;
      param[2] = FIRMWARE_REV_HI;
      param[3] = FIRMWARE_REV_LO;
    end else begin
      param[0] = cb_status_q;
      param[1] = FRAME_END;
      param[2] = FRAME_END;
      param[3] = FRAME_END;
    end
    resp_byte = FRAME_END;
    case (kind_q)
      R_SHORT: begin
        if (idx_q == 4'h0) resp_byte = head_q;
      end
      R_ERR: begin
        if (idx_q == 4'h0) resp_byte = head_q;
        if (idx_q == 4'h1) resp_byte = aux_q;
      end
      R_FRAME: begin
        case (idx_q)
          4'h0:    resp_byte = CMD_FRAME;
          4'h1:    resp_byte = len_q;
          4'h2:    resp_byte = seq_q;
          4'h3:    resp_byte = FC_RESP_OK;
          4'h4:    resp_byte = id_q;
          4'h5:    resp_byte = param[0];
          4'h6:    resp_byte = param[1];
          4'h7:    resp_byte = param[2];
          4'h8:    resp_byte = param[3];
          default: resp_byte = FRAME_END;
        endcase
      end
      default: resp_byte = FRAME_END;
    endcase
    if (idx_q == last_q) begin
      resp_byte = FRAME_END;
    end
  end

  // outside a reply the device only ever shows the poll fill
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_byte_q <= IDLE_FILL;
    end else if (state_q == ST_SEND && !sel_idle) begin
      tx_byte_q <= resp_byte;
    end else begin
      tx_byte_q <= IDLE_FILL;
    end
  end

  // pending reset report and callback; a new event beats the clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reset_pending_q <= 1'b1;
      cb_pending_q    <= 1'b0;
      cb_status_q     <= 8'h00;
    end else begin
      if (take_reset) begin
        reset_pending_q <= 1'b0;
      end
      if (network_state_event) begin
        cb_pending_q <= 1'b1;
        cb_status_q  <= network_state_status;
      end else if (take_cb) begin
        cb_pending_q <= 1'b0;
      end
    end
  end

  // attention out of a transaction
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      notify_q <= 1'b1;
    end else if (sel_rise && (cb_pending_q || reset_pending_q)) begin
      notify_q <= 1'b1;
    end else if (network_state_event && sel_idle) begin
      notify_q <= 1'b1;
    end else if (sel_fall || wake_off) begin
      notify_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      attention_request_n <= 1'b1;
    end else if (sel_idle) begin
      attention_request_n <= ~((wake_on && state_q != ST_IGNORE)
                               || (notify_q && !wake_off));
    end else begin
      attention_request_n <= ~resp_ready_q;
    end
  end

endmodule

// File: rtl/spi_link_shifter.sv
`timescale 1ns/1ps
module spi_link_shifter
  import spi_proto_pkg::*;
(
  input  wire logic       spi_clk,
  input  wire logic       target_select_n,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte,
  output logic            rx_toggle
);

  logic [2:0] bit_q;
  logic [6:0] rx_sh_q;
  logic [7:0] tx_next_q;
  logic [7:0] tx_hold_q;

  // select idle clears the bit position so each frame starts aligned
  always_ff @(posedge spi_clk or posedge target_select_n) begin
    if (target_select_n) begin
      bit_q     <= 3'h0;
      rx_toggle <= 1'b0;
    end else begin
      bit_q <= bit_q + 3'h1;
      if (bit_q == LAST_BIT) begin
        rx_toggle <= ~rx_toggle;
      end
    end
  end

  // mosi sampled on the rising edge; the tx word is taken mid byte,
  // well away from the moments the system side may change it
  always_ff @(posedge spi_clk) begin
    rx_sh_q <= {rx_sh_q[5:0], mosi};
    if (bit_q == LAST_BIT) begin
      rx_byte <= {rx_sh_q, mosi};
    end
    if (bit_q == TX_CAPTURE_BIT) begin
      tx_next_q <= tx_byte;
    end
  end

  // miso changes on the falling edge, msb first
  always_ff @(negedge spi_clk or posedge target_select_n) begin
    if (target_select_n) begin
      tx_hold_q <= IDLE_FILL;
      miso      <= IDLE_FILL[7];
    end else if (bit_q == 3'h0) begin
      tx_hold_q <= tx_next_q;
      miso      <= tx_next_q[7];
    end else begin
      miso <= tx_hold_q[3'h7 - bit_q];
    end
  end

endmodule

// File: rtl/spi_proto_pkg.sv
package spi_proto_pkg;

  // command and framing bytes
  localparam logic [7:0] CMD_VERSION      = 8'h0A;
  localparam logic [7:0] CMD_STATUS       = 8'h0B;
  localparam logic [7:0] CMD_FRAME        = 8'hFE;
  localparam logic [7:0] FRAME_END        = 8'hA7;
  localparam logic [7:0] IDLE_FILL        = 8'hFF;
  localparam logic [7:0] MAX_FRAME_LEN    = 8'h85;

  // single byte answers
  localparam logic [7:0] VERSION_REPLY    = 8'h82;
  localparam logic [7:0] STATUS_ALIVE     = 8'hC1;

  // error codes, sent in place of a frame
  localparam logic [7:0] ERR_RESET        = 8'h00;
  localparam logic [7:0] ERR_OVERSIZE     = 8'h01;
  localparam logic [7:0] ERR_NO_END       = 8'h03;
  localparam logic [7:0] ERR_UNSUPPORTED  = 8'h04;
  localparam logic [7:0] ERR_RESERVED     = 8'h00;
  localparam logic [7:0] POWER_ON_RESET_CAUSE = 8'h02;

  // serial api message fields
  localparam logic [7:0] FC_RESP_OK       = 8'h80;
  localparam logic [7:0] ID_VERSION       = 8'h00;
  localparam logic [7:0] ID_CALLBACK      = 8'h06;
  localparam logic [7:0] ID_NETWORK_STATE = 8'h19;
  localparam logic [7:0] OFS_SEQ          = 8'h00;
  localparam logic [7:0] OFS_ID           = 8'h02;
  localparam logic [7:0] LEN_VERSION_RESP = 8'h07;
  localparam logic [7:0] LEN_CB_RESP      = 8'h04;
  localparam logic [7:0] LEN_EMPTY_RESP   = 8'h03;

  // index of the terminator within each reply
  localparam logic [3:0] LAST_SHORT       = 4'h1;
  localparam logic [3:0] LAST_ERR         = 4'h2;
  localparam logic [3:0] LAST_VERSION     = 4'(LEN_VERSION_RESP + 8'h02);
  localparam logic [3:0] LAST_CB          = 4'(LEN_CB_RESP + 8'h02);
  localparam logic [3:0] LAST_EMPTY       = 4'(LEN_EMPTY_RESP + 8'h02);

  // bit positions inside a shifted byte, and the last decode step
  localparam logic [2:0] LAST_BIT         = 3'h7;
  localparam logic [2:0] TX_CAPTURE_BIT   = 3'h3;
  localparam logic [1:0] DEC_DONE         = 2'h3;

  typedef enum logic [3:0] {
    ST_IGNORE = 4'h0,
    ST_IDLE   = 4'h1,
    ST_LEN    = 4'h2,
    ST_BODY   = 4'h3,
    ST_TERM   = 4'h4,
    ST_DECODE = 4'h5,
    ST_DRAIN  = 4'h6,
    ST_SEND   = 4'h7,
    ST_DONE   = 4'h8
  } state_t;

  typedef enum logic [1:0] {
    R_SHORT = 2'h0,
    R_ERR   = 2'h1,
    R_FRAME = 2'h2
  } resp_t;

endpackage
